// ### include/spc_defines.svh
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (word indices, byte address divided by four) and preset base (byte address bits 7:6)
// ----------------------------------------------------------------
`define SPC_A_STEPMODE  6'h00
`define SPC_A_RAMP      6'h01
`define SPC_A_IDLECUR   6'h02
`define SPC_A_PHASECUR  6'h03
`define SPC_A_NODEADDR  6'h04
`define SPC_A_LINEFMT   6'h05
`define SPC_A_CTRLSRC   6'h06
`define SPC_A_MINFREQ   6'h07
`define SPC_A_BUSCMD    6'h08
`define SPC_A_LASTPRE   6'h09
`define SPC_A_IDXU      6'h0A
`define SPC_A_IDXT      6'h0B
`define SPC_A_POSU      6'h0C
`define SPC_A_POST      6'h0D
`define SPC_A_STATUS    6'h0E
`define SPC_PRESET_BASE 2'h1
// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define SPC_RST_STEPMODE 3'h2
`define SPC_RST_RAMP     6'h0A
`define SPC_RST_IDLECUR  3'h4
`define SPC_RST_PHASECUR 6'h0A
`define SPC_RST_MINFREQ  10'h00A
`define SPC_RST_PFREQ    10'h064
`define SPC_RST_PDIR     4'hA
`define SPC_AIN_MAX      10'h004
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SPC_CLK_MHZ       250
`define SPC_CLK_HZ        28'(`SPC_CLK_MHZ * 1000000)
`define SPC_RAMP_UNIT_NS  10000
`define SPC_RAMP_UNIT_CYC ((`SPC_RAMP_UNIT_NS * `SPC_CLK_MHZ) / 1000)
`define SPC_IDLE_DELAY_MS 1000
`define SPC_IDLE_CYC      (`SPC_IDLE_DELAY_MS * 1000 * `SPC_CLK_MHZ)
`endif

// ### include/spc_pkg.sv
package spc_pkg;
  typedef enum logic [1:0] {SPC_IDLE, SPC_RUN, SPC_DECEL} spc_run_e;

  typedef struct packed {
    logic            wb_ack;
    logic [31:0]     wb_dat;
    logic [2:0]      step_mode;
    logic [5:0]      ramp;
    logic [2:0]      idle_sel;
    logic [5:0]      phase_cur;
    logic [7:0]      node_addr;
    logic [2:0]      line_fmt;
    logic [1:0]      ctrl_src;
    logic [9:0]      min_freq;
    logic [3:0]      pdir;
    logic [3:0][9:0] pfreq;
    logic [3:0][9:0] plo;
    logic [3:0][9:0] phi;
    logic [3:0]      bus_fn;
    logic            bus_dir;
    logic            bus_step;
    logic [3:0]      fn_prev;
    logic            dir_prev;
    logic            step_prev;
    spc_run_e        st;
    logic [1:0]      act;
    logic [2:0]      last;
    logic            idx_mode;
    logic            ana;
    logic            run_dir;
    logic [13:0]     cur_hz;
    logic [13:0]     tgt_hz;
    logic [27:0]     acc;
    logic [16:0]     ramp_cnt;
    logic [19:0]     accel_steps;
    logic [19:0]     rem;
    logic [9:0]      idx_u;
    logic [9:0]      idx_t;
    logic [9:0]      pos_u;
    logic [15:0]     pos_t;
    logic [27:0]     idle_cnt;
    logic            idle;
    logic            step_out;
    logic            dir_out;
    logic            pwr_en;
    logic [5:0]      cur_lim;
  } spc_state_s;
endpackage : spc_pkg

// ### hdl/spc_top.sv
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "spc_defines.svh"

module spc_top #(
  parameter int IDLE_CYC = `SPC_IDLE_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        step_i,
  input  wire logic        dir_i,
  input  wire logic        disable_i,
  input  wire logic [3:0]  fn_i,
  input  wire logic [13:0] ain_hz_i,
  output logic             step_o,
  output logic             dir_o,
  output logic             pwr_en_o,
  output logic      [5:0]  cur_lim_o,
  output logic      [2:0]  step_res_o,
  output logic      [7:0]  node_addr_o,
  output logic      [2:0]  line_fmt_o
);

  spc_pkg::spc_state_s s;
  spc_pkg::spc_state_s n;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [13:0] hz10(input logic [9:0] x);
    hz10 = 14'(x * 14'd10);
  endfunction : hz10

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
    for (int i = 0; i < 4; i++)
      wmerge[i*8 +: 8] = sel[i] ? d[i*8 +: 8] : old[i*8 +: 8];
  endfunction : wmerge

  function automatic logic [19:0] cnt_dn(input logic [9:0] u, input logic [9:0] t);
    if (u == 10'h000)
      cnt_dn = {t - 10'h001, 10'h3E7};
    else
      cnt_dn = {t, u - 10'h001};
  endfunction : cnt_dn

  function automatic logic [25:0] pos_mv(input logic [9:0] u, input logic [15:0] t,
                                         input logic rev);
    if (!rev)
      pos_mv = (u == 10'h3E7) ? {t + 16'h0001, 10'h000} : {t, u + 10'h001};
    else
      pos_mv = (u == 10'h000) ? {t - 16'h0001, 10'h3E7} : {t, u - 10'h001};
  endfunction : pos_mv

  // ----------------------------------------------------------------
  // Input source and edges
  // ----------------------------------------------------------------
  logic        bus_sel;
  logic [3:0]  fn_e;
  logic        dir_e;
  logic        step_e;
  logic [3:0]  fn_rise;
  logic        dir_rise;
  logic        step_rise;
  logic        analog;
  logic [13:0] min_hz;

  assign bus_sel   = (s.ctrl_src == 2'h1) || ((s.ctrl_src == 2'h2) && fn_i[1]);
  assign fn_e      = bus_sel ? s.bus_fn : fn_i;
  assign dir_e     = bus_sel ? s.bus_dir : dir_i;
  assign step_e    = bus_sel ? s.bus_step : step_i;
  assign fn_rise   = fn_e & ~s.fn_prev;
  assign dir_rise  = dir_e & ~s.dir_prev;
  assign step_rise = step_e & ~s.step_prev;
  assign analog    = (s.pfreq[3] <= `SPC_AIN_MAX);
  assign min_hz    = hz10(s.min_freq);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [31:0] rdw;
    logic [31:0] wv;
    logic [1:0]  pi;
    logic        found;
    logic        pulse;
    logic        tick;
    logic [16:0] rlim;
    logic [27:0] asum;
    rdw   = 32'h0000_0000;
    wv    = 32'h0000_0000;
    pi    = 2'h0;
    found = 1'b0;
    pulse = 1'b0;
    tick  = 1'b0;
    rlim  = (s.ramp == 6'h00) ? 17'h00000 : 17'(s.ramp * `SPC_RAMP_UNIT_CYC) - 17'h00001;
    asum  = s.acc + 28'(s.cur_hz);
    n     = s;
    n.wb_ack   = 1'b0;
    n.step_out = 1'b0;
    n.fn_prev  = fn_e;
    n.dir_prev = dir_e;
    n.step_prev = step_e;
    n.pwr_en   = ~disable_i;

    // Register bus, one wait state
    if (wb_cyc_i && wb_stb_i && !s.wb_ack) begin
      n.wb_ack = 1'b1;
      if (wb_adr_i[7:6] == `SPC_PRESET_BASE) begin
        unique case (wb_adr_i[3:2])
          2'h0: rdw = {31'h0, s.pdir[wb_adr_i[5:4]]};
          2'h1: rdw = {22'h0, s.pfreq[wb_adr_i[5:4]]};
          2'h2: rdw = {22'h0, s.plo[wb_adr_i[5:4]]};
          2'h3: rdw = {22'h0, s.phi[wb_adr_i[5:4]]};
        endcase
      end else if (wb_adr_i[7:6] == 2'h0) begin
        case (wb_adr_i[5:0] >> 2)
          `SPC_A_STEPMODE: rdw = {29'h0, s.step_mode};
          `SPC_A_RAMP:     rdw = {26'h0, s.ramp};
          `SPC_A_IDLECUR:  rdw = {29'h0, s.idle_sel};
          `SPC_A_PHASECUR: rdw = {26'h0, s.phase_cur};
          `SPC_A_NODEADDR: rdw = {24'h0, s.node_addr};
          `SPC_A_LINEFMT:  rdw = {29'h0, s.line_fmt};
          `SPC_A_CTRLSRC:  rdw = {30'h0, s.ctrl_src};
          `SPC_A_MINFREQ:  rdw = {22'h0, s.min_freq};
          `SPC_A_BUSCMD:   rdw = {26'h0, s.bus_step, s.bus_dir, s.bus_fn};
          `SPC_A_LASTPRE:  rdw = {29'h0, s.last};
          `SPC_A_IDXU:     rdw = {22'h0, s.idx_u};
          `SPC_A_IDXT:     rdw = {22'h0, s.idx_t};
          `SPC_A_POSU:     rdw = {22'h0, s.pos_u};
          `SPC_A_POST:     rdw = {16'h0, s.pos_t};
          `SPC_A_STATUS:   rdw = {24'h0, s.idle, s.ana, s.idx_mode, bus_sel,
                                  s.pwr_en, s.act, s.st != spc_pkg::SPC_IDLE};
          default:         rdw = 32'h0000_0000;
        endcase
      end
      n.wb_dat = wb_we_i ? 32'h0000_0000 : rdw;
      if (wb_we_i) begin
        wv = wmerge(rdw, wb_dat_i, wb_sel_i);
        if (wb_adr_i[7:6] == `SPC_PRESET_BASE) begin
          unique case (wb_adr_i[3:2])
            2'h0: n.pdir[wb_adr_i[5:4]]  = wv[0];
            2'h1: n.pfreq[wb_adr_i[5:4]] = wv[9:0];
            2'h2: n.plo[wb_adr_i[5:4]]   = wv[9:0];
            2'h3: n.phi[wb_adr_i[5:4]]   = wv[9:0];
          endcase
        end else if (wb_adr_i[7:6] == 2'h0) begin
          case (wb_adr_i[5:0] >> 2)
            `SPC_A_STEPMODE: n.step_mode = wv[2:0];
            `SPC_A_RAMP:     n.ramp      = wv[5:0];
            `SPC_A_IDLECUR:  n.idle_sel  = wv[2:0];
            `SPC_A_PHASECUR: n.phase_cur = wv[5:0];
            `SPC_A_NODEADDR: n.node_addr = wv[7:0];
            `SPC_A_LINEFMT:  n.line_fmt  = wv[2:0];
            `SPC_A_CTRLSRC:  n.ctrl_src  = wv[1:0];
            `SPC_A_MINFREQ:  n.min_freq  = wv[9:0];
            `SPC_A_BUSCMD:
            begin
              n.bus_fn   = wv[3:0];
              n.bus_dir  = wv[4];
              n.bus_step = wv[5];
            end
            default: ;
          endcase
        end
      end
    end

    // Sequencer
    unique case (s.st)
      spc_pkg::SPC_IDLE:
      begin
        for (int i = 3; i >= 0; i--)
          if (fn_rise[i] && (i < 2 || !analog)) begin
            found = 1'b1;
            pi    = 2'(i);
          end
        if (found) begin
          n.st          = spc_pkg::SPC_RUN;
          n.act         = pi;
          n.last        = {1'b0, pi} + 3'h1;
          n.ana         = 1'b0;
          n.run_dir     = s.pdir[pi];
          n.tgt_hz      = hz10(s.pfreq[pi]);
          n.cur_hz      = min_hz;
          n.acc         = 28'h0;
          n.ramp_cnt    = 17'h0;
          n.accel_steps = 20'h0;
          n.rem         = 20'(s.plo[pi]) + 20'(20'(s.phi[pi]) * 20'd1000);
          n.idx_u       = s.plo[pi];
          n.idx_t       = s.phi[pi];
          n.idx_mode    = (s.plo[pi] != 10'h0) || (s.phi[pi] != 10'h0);
        end else if (analog && ain_hz_i >= min_hz && ain_hz_i != 14'h0) begin
          n.st          = spc_pkg::SPC_RUN;
          n.act         = 2'h3;
          n.ana         = 1'b1;
          n.idx_mode    = 1'b0;
          n.run_dir     = fn_e[2];
          n.tgt_hz      = ain_hz_i;
          n.cur_hz      = min_hz;
          n.acc         = 28'h0;
          n.ramp_cnt    = 17'h0;
        end else if (dir_rise && s.idx_mode) begin
          n.rem   = 20'h0;
          n.idx_u = 10'h0;
          n.idx_t = 10'h0;
          n.pos_u = 10'h0;
          n.pos_t = 16'h0;
        end else if (step_rise && !disable_i) begin
          pulse     = 1'b1;
          n.dir_out = dir_e;
        end
      end
      spc_pkg::SPC_RUN, spc_pkg::SPC_DECEL:
      begin
        if (s.ana)
          n.tgt_hz = ain_hz_i;
        if (!disable_i) begin
          tick       = (s.ramp_cnt >= rlim);
          n.ramp_cnt = tick ? 17'h0 : s.ramp_cnt + 17'h1;
          if (tick) begin
            if (s.st == spc_pkg::SPC_DECEL || s.cur_hz > s.tgt_hz)
              n.cur_hz = (s.cur_hz > 14'h0) ? s.cur_hz - 14'h1 : s.cur_hz;
            else if (s.cur_hz < s.tgt_hz)
              n.cur_hz = s.cur_hz + 14'h1;
          end
          if (asum >= `SPC_CLK_HZ) begin
            pulse     = 1'b1;
            n.acc     = asum - `SPC_CLK_HZ;
            n.dir_out = s.run_dir;
          end else begin
            n.acc = asum;
          end
        end
        if (pulse && s.st == spc_pkg::SPC_RUN && s.cur_hz < s.tgt_hz)
          n.accel_steps = s.accel_steps + 20'h1;
        if (pulse && s.idx_mode && s.rem != 20'h0) begin
          n.rem             = s.rem - 20'h1;
          {n.idx_t, n.idx_u} = cnt_dn(s.idx_u, s.idx_t);
        end
        if (dir_rise && !s.ana) begin
          n.st = disable_i ? spc_pkg::SPC_IDLE : spc_pkg::SPC_DECEL;
          if (s.idx_mode) begin
            n.rem   = 20'h0;
            n.idx_u = 10'h0;
            n.idx_t = 10'h0;
            n.pos_u = 10'h0;
            n.pos_t = 16'h0;
          end
        end else if (s.idx_mode && pulse && s.rem == 20'h1) begin
          n.st = spc_pkg::SPC_IDLE;
        end else if (s.st == spc_pkg::SPC_RUN) begin
          if (s.ana && ain_hz_i < min_hz)
            n.st = spc_pkg::SPC_DECEL;
          else if (!s.ana && !s.idx_mode && !fn_e[s.act])
            n.st = spc_pkg::SPC_DECEL;
          else if (s.idx_mode && s.rem <= s.accel_steps)
            n.st = spc_pkg::SPC_DECEL;
        end else if (s.cur_hz <= min_hz) begin
          n.st = spc_pkg::SPC_IDLE;
        end
      end
      default: n.st = spc_pkg::SPC_IDLE;
    endcase

    // Position and standstill current
    if (pulse && !(dir_rise && s.idx_mode && s.st != spc_pkg::SPC_IDLE))
      {n.pos_t, n.pos_u} = pos_mv(s.pos_u, s.pos_t, n.dir_out);
    n.step_out = pulse;
    if (pulse) begin
      n.idle_cnt = 28'h0;
      n.idle     = 1'b0;
    end else if (s.st == spc_pkg::SPC_IDLE && !s.idle) begin
      if (s.idle_cnt >= 28'(IDLE_CYC - 1))
        n.idle = 1'b1;
      else
        n.idle_cnt = s.idle_cnt + 28'h1;
    end
    if (!s.idle)
      n.cur_lim = s.phase_cur;
    else
      case (s.idle_sel)
        3'h1:    n.cur_lim = s.phase_cur;
        3'h2:    n.cur_lim = s.phase_cur >> 1;
        3'h3:    n.cur_lim = s.phase_cur >> 2;
        default: n.cur_lim = 6'h00;
      endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i) begin
      s           <= '0;
      s.st        <= spc_pkg::SPC_IDLE;
      s.step_mode <= `SPC_RST_STEPMODE;
      s.ramp      <= `SPC_RST_RAMP;
      s.idle_sel  <= `SPC_RST_IDLECUR;
      s.phase_cur <= `SPC_RST_PHASECUR;
      s.cur_lim   <= `SPC_RST_PHASECUR;
      s.min_freq  <= `SPC_RST_MINFREQ;
      s.pdir      <= `SPC_RST_PDIR;
      s.pfreq     <= {4{`SPC_RST_PFREQ}};
    end else begin
      s <= n;
    end
  end

  assign wb_dat_o    = s.wb_dat;
  assign wb_ack_o    = s.wb_ack;
  assign step_o      = s.step_out;
  assign dir_o       = s.dir_out;
  assign pwr_en_o    = s.pwr_en;
  assign cur_lim_o   = s.cur_lim;
  assign step_res_o  = s.step_mode;
  assign node_addr_o = s.node_addr;
  assign line_fmt_o  = s.line_fmt;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_dis_off;
    disable_i |=> !pwr_en_o && !step_o;
  endproperty
  a_dis_off: assert property (p_dis_off) else $error("power on while disabled");

  property p_dis_hold;
    disable_i && s.st == spc_pkg::SPC_RUN && !dir_rise |=> s.cur_hz == $past(s.cur_hz);
  endproperty
  a_dis_hold: assert property (p_dis_hold) else $error("rate moved while disabled");

  property p_ext_step;
    s.st == spc_pkg::SPC_IDLE && fn_rise == 4'h0 && !analog && !s.idx_mode
      && step_rise && !disable_i |=> step_o && dir_o == $past(dir_e);
  endproperty
  a_ext_step: assert property (p_ext_step) else $error("step pulse lost");

  property p_stop;
    s.st == spc_pkg::SPC_RUN && dir_rise && !s.ana |=> s.st != spc_pkg::SPC_RUN;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");

  property p_home;
    s.st == spc_pkg::SPC_IDLE && fn_rise == 4'h0 && !analog && dir_rise && s.idx_mode
      |=> s.pos_u == 10'h0 && s.pos_t == 16'h0 && s.idx_u == 10'h0 && s.idx_t == 10'h0;
  endproperty
  a_home: assert property (p_home) else $error("homing did not clear");

  property p_start_low;
    s.st == spc_pkg::SPC_IDLE && fn_rise[0] |=> s.st == spc_pkg::SPC_RUN
      && s.act == 2'h0 && s.last == 3'h1 && s.cur_hz == $past(min_hz);
  endproperty
  a_start_low: assert property (p_start_low) else $error("wrong preset start");

  property p_ramp_step;
    s.st != spc_pkg::SPC_IDLE ##1 s.st != spc_pkg::SPC_IDLE
      |-> (s.cur_hz - $past(s.cur_hz) <= 14'h1) || ($past(s.cur_hz) - s.cur_hz <= 14'h1);
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("rate jumped");

  property p_idle_quarter;
    s.idle && s.idle_sel == 3'h3 ##1 s.idle |-> cur_lim_o == ($past(s.phase_cur) >> 2);
  endproperty
  a_idle_quarter: assert property (p_idle_quarter) else $error("idle current wrong");

  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus answer timing wrong");

endmodule : spc_top

// ### test/spc_plc_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Controller driving the step, direction, disable and preset pins
// ----------------------------------------------------------------
module spc_plc_model (
  input  wire logic        clk_i,
  output logic             step_o,
  output logic             dir_o,
  output logic             dis_o,
  output logic [3:0]       fn_o,
  output logic [13:0]      ain_o
);
  initial
  begin
    step_o = 1'b0;
    dir_o  = 1'b0;
    dis_o  = 1'b0;
    fn_o   = 4'h0;
    ain_o  = 14'h0000;
  end

  // One pulse, one low cycle after it
  task automatic pulse_step(input logic dir);
    @(posedge clk_i);
    dir_o  <= dir;
    step_o <= 1'b1;
    @(posedge clk_i);
    step_o <= 1'b0;
    @(posedge clk_i);
  endtask : pulse_step

  // Low first, so a pin left high still gives a leading edge
  task automatic pulse_dir;
    @(posedge clk_i);
    dir_o <= 1'b0;
    @(posedge clk_i);
    dir_o <= 1'b1;
    @(posedge clk_i);
    dir_o <= 1'b0;
    @(posedge clk_i);
  endtask : pulse_dir

  task automatic set_ain(input logic [13:0] hz);
    @(posedge clk_i);
    ain_o <= hz;
  endtask : set_ain

  task automatic set_fn(input logic [3:0] f);
    @(posedge clk_i);
    fn_o <= f;
  endtask : set_fn

  // Functions are dropped in the same cycle that power comes back
  task automatic set_dis(input logic d);
    @(posedge clk_i);
    if (!d)
      fn_o <= 4'h0;
    dis_o <= d;
  endtask : set_dis
endmodule : spc_plc_model

// ### test/spc_top_tb_top.sv
`timescale 1ns/1ps

module spc_top_tb_top;
  localparam int IDLE_CYC = 50;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        step_i, dir_i, disable_i, step_o, dir_o, pwr_en_o;
  logic [3:0]  fn_i;
  logic [13:0] ain_hz_i;
  logic [5:0]  cur_lim_o;
  logic [2:0]  step_res_o, line_fmt_o;
  logic [7:0]  node_addr_o;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_steps = 0;
  int          n0;
  logic [3:0]  sel_v = 4'hF;

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  spc_top #(.IDLE_CYC(IDLE_CYC)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .step_i(step_i), .dir_i(dir_i),
    .disable_i(disable_i), .fn_i(fn_i), .ain_hz_i(ain_hz_i), .step_o(step_o),
    .dir_o(dir_o), .pwr_en_o(pwr_en_o), .cur_lim_o(cur_lim_o), .step_res_o(step_res_o),
    .node_addr_o(node_addr_o), .line_fmt_o(line_fmt_o));

  spc_plc_model u_plc (
    .clk_i(clk_i), .step_o(step_i), .dir_o(dir_i), .dis_o(disable_i),
    .fn_o(fn_i), .ain_o(ain_hz_i));

  always @(posedge clk_i)
    if (step_o === 1'b1)
      n_steps <= n_steps + 1;

  initial
  begin
    repeat (98000) @(posedge clk_i);
    n_mismatch++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Bus access and comparison
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel_v;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 100);
    rd = wb_dat_o;
    if (k >= 100)
      n_mismatch++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk

  task automatic wait_idle;
    int k;
    k = 0;
    do
    begin
      wb(1'b0, 8'h38, 32'h0000_0000);
      k++;
    end
    while (rd[0] === 1'b1 && k < 30000);
    if (k >= 30000)
      n_mismatch++;
  endtask : wait_idle

  task automatic final_report;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_i    = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(8'h00, 32'h2);
    rdchk(8'h04, 32'hA);
    rdchk(8'h08, 32'h4);
    rdchk(8'h0C, 32'hA);
    rdchk(8'h1C, 32'hA);
    rdchk(8'h40, 32'h0);
    rdchk(8'h50, 32'h1);
    rdchk(8'h60, 32'h0);
    rdchk(8'h70, 32'h1);
    rdchk(8'h48, 32'h0);
    rdchk(8'h4C, 32'h0);
    rdchk(8'h24, 32'h0);
    wb(1'b1, 8'h24, 32'h3);
    rdchk(8'h24, 32'h0);
    rdchk(8'h3C, 32'h0);
    chk(32'(cur_lim_o), 32'hA);
    for (int m = 0; m < 7; m++)
    begin
      wb(1'b1, 8'h00, 32'(m));
      repeat (2) @(posedge clk_i);
      chk(32'(step_res_o), 32'(m));
    end
    wb(1'b1, 8'h10, 32'hF7);
    wb(1'b1, 8'h14, 32'h5);
    repeat (2) @(posedge clk_i);
    chk(32'(node_addr_o), 32'hF7);
    chk(32'(line_fmt_o), 32'h5);
    sel_v = 4'h2;
    wb(1'b1, 8'h10, 32'h0000_0011);
    sel_v = 4'hF;
    repeat (2) @(posedge clk_i);
    chk(32'(node_addr_o), 32'hF7);

    // External steps and standstill current
    wb(1'b1, 8'h08, 32'h2);
    repeat (3) u_plc.pulse_step(1'b1);
    repeat (2) @(posedge clk_i);
    chk(32'(n_steps), 32'h3);
    chk(32'(dir_o), 32'h1);
    u_plc.pulse_step(1'b0);
    repeat (2) @(posedge clk_i);
    chk(32'(dir_o), 32'h0);
    chk(32'(cur_lim_o), 32'hA);
    repeat (IDLE_CYC + 20) @(posedge clk_i);
    chk(32'(cur_lim_o), 32'h5);
    wb(1'b1, 8'h08, 32'h3);
    repeat (2) @(posedge clk_i);
    chk(32'(cur_lim_o), 32'h2);
    wb(1'b1, 8'h08, 32'h4);
    repeat (2) @(posedge clk_i);
    chk(32'(cur_lim_o), 32'h0);

    // Disable blocks steps
    u_plc.set_dis(1'b1);
    repeat (2) @(posedge clk_i);
    chk(32'(pwr_en_o), 32'h0);
    u_plc.pulse_step(1'b1);
    repeat (2) @(posedge clk_i);
    chk(32'(n_steps), 32'h4);
    u_plc.set_dis(1'b0);
    repeat (2) @(posedge clk_i);
    chk(32'(pwr_en_o), 32'h1);

    // Preset run of two increments, two inputs raised together
    wb(1'b1, 8'h1C, 32'h3E8);
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b1, 8'h40, 32'h1);
    wb(1'b1, 8'h44, 32'h3E8);
    wb(1'b1, 8'h54, 32'h3E8);
    wb(1'b1, 8'h48, 32'h2);
    n0 = n_steps;
    u_plc.set_fn(4'h3);
    repeat (4) @(posedge clk_i);
    wb(1'b0, 8'h38, 32'h0);
    chk(32'(rd[0]), 32'h1);
    u_plc.set_fn(4'h0);
    wait_idle();
    chk(32'(n_steps - n0), 32'h2);
    chk(32'(dir_o), 32'h1);
    rdchk(8'h24, 32'h1);
    rdchk(8'h28, 32'h0);
    rdchk(8'h30, 32'h3E4);
    rdchk(8'h34, 32'hFFFF);
    u_plc.pulse_dir();
    rdchk(8'h30, 32'h0);
    rdchk(8'h34, 32'h0);

    // Continuous preset stopped by its input, then by the direction pin
    u_plc.set_fn(4'h2);
    repeat (4) @(posedge clk_i);
    wb(1'b0, 8'h38, 32'h0);
    chk(32'(rd[0]), 32'h1);
    u_plc.set_fn(4'h0);
    wait_idle();
    chk(32'(rd[0]), 32'h0);
    u_plc.set_fn(4'h2);
    repeat (4) @(posedge clk_i);
    wb(1'b0, 8'h38, 32'h0);
    chk(32'(rd[0]), 32'h1);
    u_plc.pulse_dir();
    wait_idle();
    chk(32'(rd[0]), 32'h0);
    rdchk(8'h24, 32'h2);

    // Analog speed, third input only steers
    wb(1'b1, 8'h74, 32'h0);
    u_plc.set_fn(4'h4);
    u_plc.set_ain(14'h2710);
    repeat (4) @(posedge clk_i);
    wb(1'b0, 8'h38, 32'h0);
    chk(32'(rd[6]), 32'h1);
    chk(32'(rd[0]), 32'h1);
    rdchk(8'h24, 32'h2);
    u_plc.set_ain(14'h0000);
    wait_idle();
    chk(32'(rd[0]), 32'h0);

    // Control source selection
    u_plc.set_fn(4'h0);
    wb(1'b1, 8'h18, 32'h2);
    u_plc.set_fn(4'h2);
    wb(1'b0, 8'h38, 32'h0);
    chk(32'(rd[4]), 32'h1);
    u_plc.set_fn(4'h0);
    wb(1'b0, 8'h38, 32'h0);
    chk(32'(rd[4]), 32'h0);
    wb(1'b1, 8'h18, 32'h1);
    wb(1'b0, 8'h38, 32'h0);
    chk(32'(rd[4]), 32'h1);

    // Reset while stopped restores defaults
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(8'h00, 32'h2);
    rdchk(8'h18, 32'h0);
    final_report();
  end
endmodule : spc_top_tb_top
